// ### verif/test_adcacc_top.sv
// Self-checking bench for the accumulate and format stage.
// Assumes the design top alone, driven directly at a 50 ns clock.
`timescale 1ns/1ps
module test_adcacc_top;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, conv_done = 1'b0, result_valid;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, conversion_output_word, lfsr = 16'h5049, exp_w;
  logic [11:0] conv_value = 12'h000;
  logic [15:0] exp_q[$];
  int err_total = 0, checked = 0;
  adcacc_top DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .conv_value(conv_value), .conv_done(conv_done), .conversion_output_word(conversion_output_word),
    .result_valid(result_valid));
  // Free-running clock.
  always #25 clk = ~clk;
  function automatic logic [15:0] step(input logic [15:0] s);
    step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample mid-cycle.
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", e, rdata);
  endtask
  // Each sequence feeds 2^v back-to-back samples, every one of them summed.
  task automatic run_seq(input int v, input logic la, input logic df);
    logic signed [31:0] s;
    s = 0;
    wr_reg(adcacc_pkg::OFF_CTRL, {9'h000, 3'(v), 2'h0, df, la});
    for (int i = 0; i < (1 << v); i++)
    begin
      @(posedge clk);
      lfsr = step(lfsr);
      conv_done <= 1'b1;
      conv_value <= lfsr[11:0];
      s += df ? 32'(signed'(lfsr[11:0])) : 32'(lfsr[11:0]);
    end
    @(posedge clk);
    conv_done <= 1'b0;
    exp_w = v > 4 ? 16'(s >>> (v - 4)) : la ? 16'(s << (4 - v)) : s[15:0];
    exp_q.push_back(exp_w);
    repeat (3) @(posedge clk);
    rd_chk(adcacc_pkg::OFF_CTRL, {9'h000, 3'(v), 2'h0, df, la});
    rd_chk(adcacc_pkg::OFF_STATUS, 16'h0001);
    rd_chk(adcacc_pkg::OFF_RESULT, exp_w);
    rd_chk(adcacc_pkg::OFF_STATUS, 16'h0000);
    $display("sequence count %0d left %0d diff %0d done", 1 << v, la, df);
  endtask
  // Every result pulse must match exactly one pending sequence; read mid-cycle where it has settled.
  always @(negedge clk)
    if (result_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk("extra result", 16'h0000, 16'h0001);
      else
        chk("result", exp_q.pop_front(), conversion_output_word);
    end
  // Main sequence: every count, alignment and polarity.
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("reset word", 16'h0000, conversion_output_word);
    rd_chk(4'h5, 16'h0000);
    for (int v = 0; v < 8; v++)
      for (int m = 0; m < 4; m++)
        run_seq(v, m[0], m[1]);
    wr_reg(adcacc_pkg::OFF_RESULT, 16'hffff);
    rd_chk(adcacc_pkg::OFF_RESULT, exp_w);
    chk("pending results", 16'h0000, 16'(exp_q.size()));
    $display("read-only and unmapped access done");
    finish_test();
  end
  // Watchdog well beyond the expected run time.
  initial
  begin
    #(50 * 20000);
    err_total++;
    finish_test();
  end
endmodule

// ### verilog/adcacc_pkg.sv
// Package for the converter result accumulation and formatting block.
// Assumes a 12-bit raw conversion value and a 16-bit result word.
package adcacc_pkg;

  // Raw conversion and result widths.
  localparam int RAW_W = 12;
  localparam int RES_W = 16;
  localparam int SUM_W = 19;

  // Register offsets on the plain register port.
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_RESULT = 4'h1;
  localparam logic [3:0] OFF_STATUS = 4'h2;

  // Control register field positions.
  localparam int CTRL_LEFT_POS = 0;
  localparam int CTRL_DIFF_POS = 1;
  localparam int CTRL_SNUM_POS = 4;
  localparam int SNUM_W = 3;

  // Reset values.
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] RESULT_RST = 16'h0000;

  // Sample counts above this exponent are truncated (16 samples).
  localparam logic [2:0] SNUM_FULL = 3'h4;
  localparam logic [2:0] SNUM_MAX = 3'h7;

  // Accumulator states, Gray coded.
  typedef enum logic [1:0] {
    ADCACC_IDLE = 2'b00,
    ADCACC_SUM = 2'b01
  } adcacc_state_t;

  // Control fields captured together.
  typedef struct packed {
    logic [2:0] sample_count_select;
    logic diff_mode;
    logic left_align_select;
  } adcacc_ctrl_t;

  // Whole block state except the registered result pulse.
  typedef struct packed {
    adcacc_state_t state;
    adcacc_ctrl_t ctrl;
    adcacc_ctrl_t run;
    logic [SUM_W-1:0] sum;
    logic [7:0] count;
    logic [15:0] result;
    logic result_ready;
    logic [15:0] rdata;
  } adcacc_regs_t;

endpackage

// ### verilog/adcacc_top.sv
// Accumulation and result formatting stage of a 12-bit converter.
// Assumes the converter core gives a raw value with a one-cycle done strobe.
//
// Overview of operation
// - Default right-adjusted result, low byte LSbs.
// - Left-align bit moves MSbs to high byte.
// - Sum consecutive samples chosen by count field.
// - Above 16 samples drop LSbs to fit.
// - Single sample at 11..0 or 15..4.
// - Sum grows one bit per sample doubling.
// - Differential pads sign above, single-ended zeros.
// - Single-ended unsigned, differential two's complement.
`timescale 1ns/1ps
module adcacc_top
(
  input wire logic clk, // 20 MHz clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [3:0] addr, // Register address.
  input wire logic [15:0] wdata, // Write data.
  input wire logic wr, // Write strobe.
  input wire logic rd, // Read strobe.
  output logic [15:0] rdata, // Read data, one cycle after rd.
  input wire logic [adcacc_pkg::RAW_W-1:0] conv_value, // Raw conversion value.
  input wire logic conv_done, // One-cycle conversion done strobe.
  output logic [15:0] conversion_output_word, // Formatted result.
  output logic result_valid // One-cycle pulse on result update.
);

  adcacc_pkg::adcacc_regs_t q_r;
  adcacc_pkg::adcacc_regs_t q_nxt;
  logic valid_nxt;
  logic valid_r;
  logic [adcacc_pkg::SUM_W-1:0] ext_sample;
  logic [adcacc_pkg::SUM_W-1:0] sum_add;
  logic [adcacc_pkg::SUM_W-1:0] shifted;
  logic [15:0] fmt;
  logic [7:0] last_count;
  logic [4:0] width;
  adcacc_pkg::adcacc_ctrl_t cfg;

  // Settings in force: idle follows the control register, a running sequence keeps its own copy.
  assign cfg = (q_r.state == adcacc_pkg::ADCACC_IDLE) ? q_r.ctrl : q_r.run;

  // Extend sample per mode; sign copy for differential input.
  // signed versus unsigned
  always_comb
  begin
    if (cfg.diff_mode)
      ext_sample = {{(adcacc_pkg::SUM_W-adcacc_pkg::RAW_W){conv_value[11]}}, conv_value};
    else
      ext_sample = {{(adcacc_pkg::SUM_W-adcacc_pkg::RAW_W){1'b0}}, conv_value};
  end

  assign sum_add = (q_r.count == 8'h00 ? '0 : q_r.sum) + ext_sample;
  assign last_count = 8'((9'h001 << cfg.sample_count_select) - 9'h001);

  // Format the finished sum into the 16-bit word.
  // The sum width is 12 plus the count exponent, capped by truncation at 16.
  always_comb
  begin
    shifted = sum_add;
    width = 5'(12 + cfg.sample_count_select);
    fmt = 16'h0000;
    if (cfg.sample_count_select > adcacc_pkg::SNUM_FULL)
    begin
      shifted = sum_add >>> (cfg.sample_count_select - adcacc_pkg::SNUM_FULL);
      if (cfg.diff_mode)
        shifted = $signed(sum_add) >>> (cfg.sample_count_select - adcacc_pkg::SNUM_FULL);
      width = 5'd16;
    end
    if (cfg.left_align_select)
      fmt = 16'(shifted << (5'd16 - width));
    else
      fmt = shifted[15:0];
  end

  // Next-state logic for registers, accumulator and read port.
  always_comb
  begin
    q_nxt = q_r;
    valid_nxt = 1'b0;
    q_nxt.rdata = 16'h0000;
    if (wr && addr == adcacc_pkg::OFF_CTRL)
    begin
      q_nxt.ctrl.left_align_select = wdata[adcacc_pkg::CTRL_LEFT_POS];
      q_nxt.ctrl.diff_mode = wdata[adcacc_pkg::CTRL_DIFF_POS];
      q_nxt.ctrl.sample_count_select = wdata[adcacc_pkg::CTRL_SNUM_POS +: adcacc_pkg::SNUM_W];
    end
    // Reads of the result clear the ready flag; a new result wins.
    if (rd)
    begin
      case (addr)
        adcacc_pkg::OFF_CTRL:
          q_nxt.rdata = {9'h000, q_r.ctrl.sample_count_select, 2'b00, q_r.ctrl.diff_mode,
                         q_r.ctrl.left_align_select};
        adcacc_pkg::OFF_RESULT:
        begin
          q_nxt.rdata = q_r.result;
          q_nxt.result_ready = 1'b0;
        end
        adcacc_pkg::OFF_STATUS:
          q_nxt.rdata = {14'h0000, q_r.state == adcacc_pkg::ADCACC_SUM, q_r.result_ready};
        default:
          q_nxt.rdata = 16'h0000;
      endcase
    end
    // Settings latch at sequence start so mid-sequence writes cannot mix formats.
    q_nxt.run = cfg;
    case (q_r.state)
      adcacc_pkg::ADCACC_IDLE:
      begin
        q_nxt.count = 8'h00;
        q_nxt.sum = '0;
      end
      adcacc_pkg::ADCACC_SUM:
        q_nxt.state = adcacc_pkg::ADCACC_SUM;
      default:
      begin
        q_nxt.state = adcacc_pkg::ADCACC_IDLE;
        q_nxt.count = 8'h00;
      end
    endcase
    // The opening sample is summed too, so a single-sample setting never drops a conversion.
    // add each sample
    if (conv_done)
    begin
      q_nxt.sum = sum_add;
      q_nxt.count = q_r.count + 8'h01;
      q_nxt.state = adcacc_pkg::ADCACC_SUM;
      if (q_r.count == last_count)
      begin
        q_nxt.result = fmt;
        q_nxt.result_ready = 1'b1;
        valid_nxt = 1'b1;
        q_nxt.count = 8'h00;
        q_nxt.state = adcacc_pkg::ADCACC_IDLE;
      end
    end
  end

  // State register.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q_r <= '0;
      q_r.ctrl <= adcacc_pkg::CTRL_RST[4:0];
      q_r.result <= adcacc_pkg::RESULT_RST;
      valid_r <= 1'b0;
    end
    else
    begin
      q_r <= q_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign rdata = q_r.rdata;
  assign conversion_output_word = q_r.result;
  assign result_valid = valid_r;

  // Checks on the finished word; the latched settings still describe it while the pulse stands.

  property p_word_hold;
    @(posedge clk) disable iff (rst)
    !result_valid |-> conversion_output_word == $past(conversion_output_word);
  endproperty
  a_word_hold: assert property (p_word_hold)
    else $error("result word changed without a result pulse");

  property p_valid_after_sample;
    @(posedge clk) disable iff (rst)
    result_valid |-> $past(conv_done);
  endproperty
  a_valid_after_sample: assert property (p_valid_after_sample)
    else $error("result pulse without a sample before it");

  property p_ready_with_result;
    @(posedge clk) disable iff (rst)
    result_valid |-> q_r.result_ready;
  endproperty
  a_ready_with_result: assert property (p_ready_with_result)
    else $error("result pulse without the ready flag set");

  property p_single_right;
    @(posedge clk) disable iff (rst)
    result_valid && q_r.run.sample_count_select == 3'h0 && !q_r.run.left_align_select && !q_r.run.diff_mode
      |-> conversion_output_word == {4'h0, $past(conv_value)};
  endproperty
  a_single_right: assert property (p_single_right)
    else $error("single sample not right-adjusted with zero padding");

  property p_single_left;
    @(posedge clk) disable iff (rst)
    result_valid && q_r.run.sample_count_select == 3'h0 && q_r.run.left_align_select
      |-> conversion_output_word == {$past(conv_value), 4'h0};
  endproperty
  a_single_left: assert property (p_single_left)
    else $error("single sample not left-adjusted with low zeros");

  property p_right_zero_pad;
    @(posedge clk) disable iff (rst)
    result_valid && !q_r.run.diff_mode && !q_r.run.left_align_select &&
      q_r.run.sample_count_select < adcacc_pkg::SNUM_FULL
      |-> (conversion_output_word >> (5'd12 + 5'(q_r.run.sample_count_select))) == 16'h0000;
  endproperty
  a_right_zero_pad: assert property (p_right_zero_pad)
    else $error("single-ended right-adjusted sum not zero padded");

  property p_right_sign_pad;
    @(posedge clk) disable iff (rst)
    result_valid && q_r.run.diff_mode && !q_r.run.left_align_select &&
      q_r.run.sample_count_select < adcacc_pkg::SNUM_FULL
      |-> ((conversion_output_word ^ {16{conversion_output_word[15]}}) >>
           (5'd11 + 5'(q_r.run.sample_count_select))) == 16'h0000;
  endproperty
  a_right_sign_pad: assert property (p_right_sign_pad)
    else $error("differential right-adjusted sum not sign extended");

  property p_left_low_zero;
    @(posedge clk) disable iff (rst)
    result_valid && q_r.run.left_align_select && q_r.run.sample_count_select < adcacc_pkg::SNUM_FULL
      |-> (conversion_output_word & ~(16'hffff << (3'h4 - q_r.run.sample_count_select))) == 16'h0000;
  endproperty
  a_left_low_zero: assert property (p_left_low_zero)
    else $error("left-adjusted sum has nonzero low bits");

endmodule
